/* File: logic/jcs_tap_device.sv */
// Device end: test access port controller with clock-option scan cells
`include "jcs_cfg.svh"
`default_nettype none
module jcs_tap_device
  import jcs_pkg::*;
#(
  parameter logic [31:0] IDCODE_VALUE = 32'h0A5A_5001  // Arbitrary identity value
) (
  jcs_link_if.dut               link,
  input  wire logic [4:0]       sys_clock_enable,
  input  wire logic [4:0]       clock_source_line,
  input  wire logic [2:0]       clock_option_fuse,
  input  wire logic             timer_osc_in_use,
  input  wire logic             internal_load_cap_setting,
  input  wire logic             crystal_needs_cap,
  output logic                  ext_clock_scan_enable,
  output logic                  crystal_osc_scan_enable,
  output logic                  rc_osc_scan_enable,
  output logic                  lowfreq_crystal_scan_enable,
  output logic                  timer_osc_scan_enable,
  output logic                  crystal_osc_run,
  output logic [`JCS_IR_W-1:0]  active_instruction
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  jcs_tap_state_type              state;
  jcs_tap_state_type              next_state;
  logic [`JCS_IR_W-1:0]           ir_shift;
  logic [`JCS_IR_W-1:0]           ir;
  logic                           dr_bypass;
  logic [31:0]                    dr_id;
  logic [`JCS_BSR_W-1:0]          dr_bsr;
  logic [`JCS_BSR_W-1:0]          bsr_hold;
  logic [`JCS_BSR_W-1:0]          cell_capture;
  logic [`JCS_PIN_W-1:0]          pin_sync;
  logic [4:0]                     en_sys;
  logic [4:0]                     line_raw;
  logic [2:0]                     fuse_sync;
  logic                           timer_used_sync;
  logic                           cap_set_sync;
  logic                           needs_cap_sync;
  logic [2:0]                     fuse_held;
  logic                           timer_used_held;
  logic [1:0]                     cfg_wait;
  logic                           cfg_loaded;
  logic [`JCS_NUM_CELLS-1:0]      opt_used;
  logic [`JCS_NUM_CELLS-1:0]      scan_line;
  logic [`JCS_NUM_CELLS-1:0]      scan_enable;
  logic [`JCS_NUM_CELLS-1:0]      next_scan_enable;
  logic                           extest;
  logic                           bsr_sel;
  logic                           tdo_next;
  localparam logic [`JCS_NUM_CELLS-1:0] IDLE_LEVELS = `JCS_IDLE_LEVELS;

  // ****************************************************************
  // Pin synchronisers into the test clock domain
  // ****************************************************************
  jcs_sync #(
    .W (`JCS_PIN_W)
  ) u_pin_sync (
    .clk   (link.tck),
    .rst_n (link.trst_n),
    .d     ({crystal_needs_cap, internal_load_cap_setting,
             timer_osc_in_use, clock_option_fuse, clock_source_line, sys_clock_enable}),
    .q     (pin_sync)
  );

  // Bundle positions of the synchronised pins
  assign en_sys          = pin_sync[4:0];
  assign line_raw        = pin_sync[9:5];
  assign fuse_sync       = pin_sync[12:10];
  assign timer_used_sync = pin_sync[13];
  assign cap_set_sync    = pin_sync[14];

  // ****************************************************************
  // Clock configuration, caught once after reset
  // ****************************************************************
  always_ff @(posedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      cfg_wait        <= '0;
      cfg_loaded      <= 1'h0;
      fuse_held       <= '0;
      timer_used_held <= 1'h0;
    end else if (!cfg_loaded) begin
      if (cfg_wait == `JCS_SYNC_LAT) begin
        fuse_held       <= fuse_sync;
        timer_used_held <= timer_used_sync;
        cfg_loaded      <= 1'h1;
      end else begin
        cfg_wait <= cfg_wait + 2'h1;
      end
    end
  end

  // Load-cap requirement taken alongside the other straps
  always_ff @(posedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      needs_cap_sync <= 1'h0;
    end else if (!cfg_loaded && cfg_wait == `JCS_SYNC_LAT) begin
      needs_cap_sync <= pin_sync[`JCS_PIN_W-1];
    end
  end

  // ****************************************************************
  // Clock-option scan cells
  // ****************************************************************
  assign extest = (ir == `JCS_IR_EXTEST);

  genvar gi;
  generate
    for (gi = 0; gi < `JCS_NUM_CELLS; gi++) begin : g_cell
      // Main options follow the fuse, the timer oscillator its own strap
      if (gi == `JCS_OPT_TIMER) begin : g_timer
        assign opt_used[gi] = timer_used_held;
      end else begin : g_main
        assign opt_used[gi] = cfg_loaded && (fuse_held == 3'(gi));
      end
      // Unused line returns its fixed idle level
      assign scan_line[gi] = opt_used[gi] ? line_raw[gi]
                                          : IDLE_LEVELS[gi];
      // Enable and line pair captured into the chain
      assign cell_capture[2*gi]   = scan_enable[gi];
      assign cell_capture[2*gi+1] = scan_line[gi];
      // Scan drives the enable in extest, system logic otherwise
      assign next_scan_enable[gi] = extest ? bsr_hold[2*gi] : en_sys[gi];
    end
  endgenerate

  // Registered enables toward the oscillators
  always_ff @(posedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      scan_enable <= '0;
    end else begin
      scan_enable <= next_scan_enable;
    end
  end

  assign ext_clock_scan_enable       = scan_enable[`JCS_OPT_EXT];
  assign crystal_osc_scan_enable     = scan_enable[`JCS_OPT_CRYSTAL];
  assign rc_osc_scan_enable          = scan_enable[`JCS_OPT_RC];
  assign lowfreq_crystal_scan_enable = scan_enable[`JCS_OPT_LOWFREQ];
  assign timer_osc_scan_enable       = scan_enable[`JCS_OPT_TIMER];

  // Crystal oscillates only when its load caps are set or it needs none
  always_ff @(posedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      crystal_osc_run <= 1'h0;
    end else begin
      crystal_osc_run <= scan_enable[`JCS_OPT_CRYSTAL]
                         & (~needs_cap_sync | cap_set_sync);
    end
  end

  // ****************************************************************
  // Test access port controller
  // ****************************************************************
  always_comb begin
    unique case (state)
      TS_RESET:  next_state = link.tms ? TS_RESET  : TS_IDLE;
      TS_IDLE:   next_state = link.tms ? TS_SEL_DR : TS_IDLE;
      TS_SEL_DR: next_state = link.tms ? TS_SEL_IR : TS_CAP_DR;
      TS_CAP_DR: next_state = link.tms ? TS_EX1_DR : TS_SH_DR;
      TS_SH_DR:  next_state = link.tms ? TS_EX1_DR : TS_SH_DR;
      TS_EX1_DR: next_state = link.tms ? TS_UPD_DR : TS_PA_DR;
      TS_PA_DR:  next_state = link.tms ? TS_EX2_DR : TS_PA_DR;
      TS_EX2_DR: next_state = link.tms ? TS_UPD_DR : TS_SH_DR;
      TS_UPD_DR: next_state = link.tms ? TS_SEL_DR : TS_IDLE;
      TS_SEL_IR: next_state = link.tms ? TS_RESET  : TS_CAP_IR;
      TS_CAP_IR: next_state = link.tms ? TS_EX1_IR : TS_SH_IR;
      TS_SH_IR:  next_state = link.tms ? TS_EX1_IR : TS_SH_IR;
      TS_EX1_IR: next_state = link.tms ? TS_UPD_IR : TS_PA_IR;
      TS_PA_IR:  next_state = link.tms ? TS_EX2_IR : TS_PA_IR;
      TS_EX2_IR: next_state = link.tms ? TS_UPD_IR : TS_SH_IR;
      TS_UPD_IR: next_state = link.tms ? TS_SEL_DR : TS_IDLE;
    endcase
  end

  // State advances on each rising test clock edge
  always_ff @(posedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      state <= TS_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // Instruction register
  // ****************************************************************
  always_ff @(posedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      ir_shift <= `JCS_IR_CAPTURE;
      ir       <= `JCS_IR_IDCODE;
    end else begin
      unique case (state)
        TS_RESET:  ir <= `JCS_IR_IDCODE;
        TS_CAP_IR: ir_shift <= `JCS_IR_CAPTURE;
        TS_SH_IR:  ir_shift <= {link.tdi, ir_shift[`JCS_IR_W-1:1]};
        TS_UPD_IR: ir <= ir_shift;
        default:   ir <= ir;
      endcase
    end
  end

  assign active_instruction = ir;

  // ****************************************************************
  // Data registers
  // ****************************************************************
  assign bsr_sel = (ir == `JCS_IR_EXTEST) || (ir == `JCS_IR_SAMPLE);

  always_ff @(posedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      dr_bypass <= 1'h0;
      dr_id     <= '0;
      dr_bsr    <= '0;
      bsr_hold  <= '0;
    end else begin
      if (state == TS_CAP_DR) begin
        dr_bypass <= 1'h0;
        dr_id     <= IDCODE_VALUE;
        dr_bsr    <= cell_capture;
      end else if (state == TS_SH_DR) begin
        if (bsr_sel) begin
          dr_bsr <= {link.tdi, dr_bsr[`JCS_BSR_W-1:1]};
        end else if (ir == `JCS_IR_IDCODE) begin
          dr_id <= {link.tdi, dr_id[31:1]};
        end else begin
          dr_bypass <= link.tdi;
        end
      end else if (state == TS_UPD_DR && bsr_sel) begin
        bsr_hold <= dr_bsr;
      end
    end
  end

  // ****************************************************************
  // Serial output, changed on the falling test clock edge
  // ****************************************************************
  always_comb begin
    if (state == TS_SH_IR) begin
      tdo_next = ir_shift[0];
    end else if (bsr_sel) begin
      tdo_next = dr_bsr[0];
    end else if (ir == `JCS_IR_IDCODE) begin
      tdo_next = dr_id[0];
    end else begin
      tdo_next = dr_bypass;
    end
  end

  always_ff @(negedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      link.tdo      <= 1'h0;
      link.tdo_oe_n <= 1'h1;
    end else begin
      link.tdo      <= tdo_next;
      link.tdo_oe_n <= ~(state == TS_SH_DR || state == TS_SH_IR);
    end
  end

endmodule
`default_nettype wire

/* File: logic/jcs_cfg.svh */
// Constants of the boundary-scan clock-option cells and the scan tester
`ifndef JCS_CFG_SVH
`define JCS_CFG_SVH

// Instruction register
`define JCS_IR_W          4
`define JCS_IR_EXTEST     4'h0
`define JCS_IR_IDCODE     4'h1
`define JCS_IR_SAMPLE     4'h2
`define JCS_IR_BYPASS     4'hF
`define JCS_IR_CAPTURE    4'h1

// Clock-option scan cells, two bits each: enable then clock line
`define JCS_NUM_CELLS     5
`define JCS_MAIN_CELLS    4
`define JCS_BSR_W         10
`define JCS_OPT_EXT       0
`define JCS_OPT_CRYSTAL   1
`define JCS_OPT_RC        2
`define JCS_OPT_LOWFREQ   3
`define JCS_OPT_TIMER     4
`define JCS_IDLE_LEVELS   5'h04
`define JCS_SYNC_LAT      2'h2
`define JCS_PIN_W         16

// Tester register map and fields
`define JCS_REG_CTRL      8'h00
`define JCS_REG_LEN       8'h04
`define JCS_REG_TX        8'h08
`define JCS_REG_RX        8'h0C
`define JCS_REG_STAT      8'h10
`define JCS_CTRL_START    0
`define JCS_CTRL_IR       1
`define JCS_CTRL_RESET    2
`define JCS_STAT_BUSY     0
`define JCS_STAT_ERR      1
`define JCS_LEN_RESET     6'h0A
`define JCS_LEN_MAX       6'h20

// Mode-select sequences, sent lsb first
`define JCS_SEQ_DR        6'h01
`define JCS_SEQ_DR_LEN    6'h03
`define JCS_SEQ_IR        6'h03
`define JCS_SEQ_IR_LEN    6'h04
`define JCS_SEQ_RST       6'h1F
`define JCS_SEQ_RST_LEN   6'h06
`define JCS_SEQ_POST      6'h01
`define JCS_SEQ_POST_LEN  6'h02
`define JCS_TCK_HALF      4

`endif

/* File: logic/jcs_pkg.sv */
// Types shared by the scan device and the scan tester
`default_nettype none
package jcs_pkg;

  // Sixteen states of the test access port controller
  typedef enum logic [3:0] {
    TS_RESET, TS_IDLE, TS_SEL_DR, TS_CAP_DR, TS_SH_DR, TS_EX1_DR, TS_PA_DR, TS_EX2_DR,
    TS_UPD_DR, TS_SEL_IR, TS_CAP_IR, TS_SH_IR, TS_EX1_IR, TS_PA_IR, TS_EX2_IR, TS_UPD_IR
  } jcs_tap_state_type;

  // Tester sequencer states
  typedef enum logic [1:0] {
    HS_IDLE, HS_PRE, HS_SHIFT, HS_POST
  } jcs_host_state_type;

endpackage
`default_nettype wire

/* File: logic/jcs_link_if.sv */
// Four-pin test access port plus test reset between tester and device
`default_nettype none
interface jcs_link_if;
  logic tck;
  logic tms;
  logic tdi;
  logic trst_n;
  logic tdo;
  logic tdo_oe_n;
  logic tdo_line;

  // Pulled-up serial output wire
  assign tdo_line = tdo_oe_n ? 1'h1 : tdo;

  modport tester (output tck, output tms, output tdi, output trst_n, input tdo_line);
  modport dut    (input tck, input tms, input tdi, input trst_n, output tdo, output tdo_oe_n);
endinterface
`default_nettype wire

/* File: logic/jcs_sync.sv */
// Two flip-flop synchroniser for a bundle of level signals
`default_nettype none
module jcs_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // First stage read only by the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

/* File: logic/jcs_tester.sv */
// Tester end: APB-controlled boundary-scan sequencer driving the test port
`include "jcs_cfg.svh"
`default_nettype none
module jcs_tester
  import jcs_pkg::*;
#(
  parameter int unsigned TCK_HALF = `JCS_TCK_HALF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  jcs_link_if.tester       link
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  jcs_host_state_type state;
  logic [7:0]         div_cnt;
  logic               tck_q;
  logic               tick;
  logic               rise;
  logic               fall;
  logic               tdo_s;
  logic [5:0]         pat;
  logic [5:0]         cnt;
  logic [5:0]         len;
  logic [31:0]        tx;
  logic [31:0]        rx;
  logic               pend;
  logic               err;
  logic               is_reset;
  logic               hit;
  logic               wr;
  logic               start;
  logic               too_many;
  logic [2:0]         n_en;

  // ****************************************************************
  // Test clock divider, reset and serial input sync
  // ****************************************************************
  assign tick = (div_cnt == 8'(TCK_HALF - 1));
  assign rise = tick & ~tck_q;
  assign fall = tick & tck_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt     <= '0;
      tck_q       <= 1'h0;
      link.trst_n <= 1'h0;
    end else begin
      div_cnt     <= tick ? 8'h00 : div_cnt + 8'h01;
      tck_q       <= tick ? ~tck_q : tck_q;
      link.trst_n <= 1'h1;
    end
  end

  assign link.tck = tck_q;

  jcs_sync #(
    .W (1)
  ) u_tdo_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (link.tdo_line),
    .q     (tdo_s)
  );

  // ****************************************************************
  // APB slave
  // ****************************************************************
  assign pready  = psel & penable;
  assign hit     = (paddr == `JCS_REG_CTRL) || (paddr == `JCS_REG_LEN) ||
                   (paddr == `JCS_REG_TX) || (paddr == `JCS_REG_RX) ||
                   (paddr == `JCS_REG_STAT);
  assign pslverr = pready & ~hit;
  assign wr      = pready & pwrite & hit;

  // Only one main clock enable may be set in a clock-chain scan
  always_comb begin
    n_en = 3'h0;
    for (int i = 0; i < `JCS_MAIN_CELLS; i++) begin
      n_en = n_en + {2'h0, tx[2*i]};
    end
  end
  assign too_many = (len == 6'(`JCS_BSR_W)) && (n_en > 3'h1) &&
                    !pwdata[`JCS_CTRL_IR] && !pwdata[`JCS_CTRL_RESET];
  assign start    = wr && (paddr == `JCS_REG_CTRL) && pwdata[`JCS_CTRL_START] &&
                    (state == HS_IDLE);

  // Read data taken in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable) begin
      unique case (paddr)
        `JCS_REG_LEN:  prdata <= {26'h0, len};
        `JCS_REG_TX:   prdata <= tx;
        `JCS_REG_RX:   prdata <= rx >> (`JCS_LEN_MAX - len);
        `JCS_REG_STAT: prdata <= {30'h0, err, state != HS_IDLE};
        default:       prdata <= '0;
      endcase
    end
  end

  // Length register, writable while idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      len <= `JCS_LEN_RESET;
    end else if (wr && paddr == `JCS_REG_LEN && state == HS_IDLE &&
                 pwdata[5:0] != 6'h00 && pwdata[5:0] <= `JCS_LEN_MAX) begin
      len <= pwdata[5:0];
    end
  end

  // Refusal flag: a new refusal wins over the clearing write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err <= 1'h0;
    end else if (start && too_many) begin
      err <= 1'h1;
    end else if (wr && paddr == `JCS_REG_STAT && pwdata[`JCS_STAT_ERR]) begin
      err <= 1'h0;
    end
  end

  // ****************************************************************
  // Scan sequencer: mode select and data change on falling test clock
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= HS_IDLE;
      pat      <= '0;
      cnt      <= '0;
      tx       <= '0;
      rx       <= '0;
      pend     <= 1'h0;
      is_reset <= 1'h0;
      link.tms <= 1'h1;
      link.tdi <= 1'h0;
    end else begin
      if (rise && pend) begin
        rx   <= {tdo_s, rx[31:1]};
        pend <= 1'h0;
      end
      unique case (state)
        HS_IDLE: begin
          if (wr && paddr == `JCS_REG_TX) begin
            tx <= pwdata;
          end
          if (start && !too_many) begin
            is_reset <= pwdata[`JCS_CTRL_RESET];
            state    <= HS_PRE;
            if (pwdata[`JCS_CTRL_RESET]) begin
              pat <= `JCS_SEQ_RST;
              cnt <= `JCS_SEQ_RST_LEN;
            end else if (pwdata[`JCS_CTRL_IR]) begin
              pat <= `JCS_SEQ_IR;
              cnt <= `JCS_SEQ_IR_LEN;
            end else begin
              pat <= `JCS_SEQ_DR;
              cnt <= `JCS_SEQ_DR_LEN;
            end
          end
        end
        HS_PRE: begin
          if (fall) begin
            link.tms <= pat[0];
            pat      <= pat >> 1;
            cnt      <= cnt - 6'h01;
            if (cnt == 6'h01) begin
              state <= is_reset ? HS_IDLE : HS_SHIFT;
              cnt   <= len;
            end
          end
        end
        HS_SHIFT: begin
          if (fall) begin
            link.tdi <= tx[0];
            tx       <= tx >> 1;
            link.tms <= (cnt == 6'h01);
            pend     <= 1'h1;
            cnt      <= cnt - 6'h01;
            if (cnt == 6'h01) begin
              state <= HS_POST;
              pat   <= `JCS_SEQ_POST;
              cnt   <= `JCS_SEQ_POST_LEN;
            end
          end
        end
        HS_POST: begin
          if (fall) begin
            link.tms <= pat[0];
            pat      <= pat >> 1;
            cnt      <= cnt - 6'h01;
            if (cnt == 6'h01) begin
              state <= HS_IDLE;
            end
          end
        end
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: sim/jcs_link_properties.sv */
// Checker of the test port wire behaviour
`default_nettype none
module jcs_link_properties (
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tms,
  input wire logic tdo,
  input wire logic tdo_oe_n,
  input wire logic tdo_line
);
  // ****************
  // Port state checks
  // ****************
  default clocking @(posedge tck); endclocking
  default disable iff (!trst_n);
  // Reset walk and the two shift entry walks
  sequence s_rst; tms [*5] ##1 !tms; endsequence
  sequence s_dr; tms ##1 !tms [*2]; endsequence
  sequence s_ir; tms [*2] ##1 !tms [*2]; endsequence
  // Run of mode-select ones; Run-Test/Idle known after a reset walk
  logic [2:0] ones;
  logic       from_idle;
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      ones      <= 3'h5;
      from_idle <= 1'h0;
    end else begin
      ones      <= tms ? ((ones == 3'h5) ? ones : ones + 3'h1) : 3'h0;
      from_idle <= !tms && (from_idle || ones == 3'h5);
    end
  end
  a_pull_up_idle: assert property (tdo_oe_n |-> tdo_line) else $error("line low");
  a_one_leaves: assert property (tms |=> tdo_oe_n) else $error("shift on one");
  a_zero_keeps: assert property (!tdo_oe_n && !tms |=> !tdo_oe_n) else $error("lost");
  a_entry_zero: assert property ($fell(tdo_oe_n) |-> !$past(tms)) else $error("entry");
  a_exit_holds: assert property ($rose(tdo_oe_n) |=> tdo_oe_n) else $error("exit");
  a_reset_quiet: assert property (s_rst ##1 !tms |=> tdo_oe_n) else $error("quiet");
  a_dr_entry: assert property (from_idle ##0 s_dr |=> !tdo_oe_n) else $error("no dr");
  a_ir_entry: assert property (from_idle ##0 s_ir |=> !tdo_oe_n) else $error("no ir");
  a_line_follows: assert property (!tdo_oe_n |-> tdo_line == tdo) else $error("tdo");
endmodule
`default_nettype wire

/* File: sim/jtag_clock_option_scan_cells_tb.sv */
// Testbench joining the scan tester and the scan device
`default_nettype none
module jtag_clock_option_scan_cells_tb
  import jcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // Design and checker
  // ****************
  localparam logic [31:0] ID = 32'h0000_3C01; // Arbitrary identity value
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic [4:0]  en = 0, line = 5'h1F;
  logic [2:0]  fuse = 0;
  logic        timer = 1, cap = 0, need = 1, e0, e1, e2, e3, e4, run;
  logic [3:0]  ir;
  int          mismatches = 0, n_checks = 0;
  jcs_link_if lnk ();
  jcs_tester #(.TCK_HALF(4)) u_jcs_tester (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(lnk));
  jcs_tap_device #(.IDCODE_VALUE(ID)) u_jcs_tap_device (.link(lnk), .sys_clock_enable(en),
    .clock_source_line(line), .clock_option_fuse(fuse), .timer_osc_in_use(timer),
    .internal_load_cap_setting(cap), .crystal_needs_cap(need), .ext_clock_scan_enable(e0),
    .crystal_osc_scan_enable(e1), .rc_osc_scan_enable(e2), .lowfreq_crystal_scan_enable(e3),
    .timer_osc_scan_enable(e4), .crystal_osc_run(run), .active_instruction(ir));
  jcs_link_properties u_jcs_link_properties (.tck(lnk.tck), .trst_n(lnk.trst_n),
    .tms(lnk.tms), .tdo(lnk.tdo), .tdo_oe_n(lnk.tdo_oe_n), .tdo_line(lnk.tdo_line));
  // Clock
  initial begin
    forever #20 pclk = ~pclk;
  end
  // ****************
  // Tasks
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One APB transfer; read data and error taken at the ready edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    if (i == 20) begin
      mismatches++;
      end_sim();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  // Length, data, start, wait for idle, then read captured bits
  task automatic scan(input logic [31:0] ctrl, input logic [31:0] len, input logic [31:0] tx);
    int i;
    bus(1, 8'h04, len);
    bus(1, 8'h08, tx);
    bus(1, 8'h00, ctrl);
    for (i = 0; i < 400; i++) begin
      bus(0, 8'h10, 0);
      if (q[0] === 1'h0) break;
    end
    if (i == 400) begin
      mismatches++;
      end_sim();
    end
    bus(0, 8'h0C, 0);
  endtask
  task automatic t_id();
    bus(0, 8'h04, 0);
    chk(q, 32'h0000_000A);
    bus(0, 8'h40, 0);
    chk({q[30:0], err}, 32'h0000_0001);
    scan(5, 10, 0);
    chk(ir, 4'h1);
    scan(1, 32, 0);
    chk(q, ID);
    $display("test id done");
  endtask
  task automatic t_chain();
    scan(5, 10, 0);
    scan(3, 4, 2);
    chk(q, 32'h0000_0001);
    chk(ir, 4'h2);
    scan(1, 10, 0);
    chk(q, 32'h0000_0222);
    fuse <= 3'h2;
    scan(1, 10, 0);
    chk(q, 32'h0000_0222);
    $display("test chain done");
  endtask
  task automatic t_ext();
    scan(3, 4, 0);
    scan(1, 10, 32'h0000_0004);
    // Enables follow the update a few test clocks later
    repeat (24) @(posedge pclk);
    chk({e4, e3, e2, e1, e0, run}, 6'h04);
    cap <= 1'h1;
    repeat (40) @(posedge pclk);
    chk(run, 1'h1);
    scan(1, 10, 32'h0000_0005);
    bus(0, 8'h10, 0);
    chk(q & 3, 32'h0000_0002);
    chk(e0, 1'h0);
    $display("test extest done");
  endtask
  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_id();
    t_chain();
    t_ext();
    end_sim();
  end
endmodule
`default_nettype wire
